// [test_timer_based_pwm_output.sv]
`timescale 1ns/1ps
module test_timer_based_pwm_output;
   import tpwm_pkg::*;
   logic        clk = 0, rst = 1, slp = 0;
   logic [4:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, v, s1;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, pin, oe, line;
   logic [1:0]  bresp, rresp;
   int          n_mismatch = 0, samples_checked = 0, p, d, nn, h, per;
   int unsigned xs_st = 88;

   tpwm_top dut_u (.clock_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .sleep_i(slp), .modulated_output_pin_o(pin),
      .modulated_output_pin_oe_o(oe));
   tpwm_load load_u (.clock_i(clk), .pin_i(pin), .oe_i(oe), .line_o(line));

   // 200 MHz system clock
   initial begin
      forever #2.5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic int unsigned xs();
      xs_st ^= xs_st << 13;
      xs_st ^= xs_st >> 17;
      xs_st ^= xs_st << 5;
      return xs_st;
   endfunction
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   // A used-up bound is a hang: report it and stop
   task automatic tmo(input int n);
      if (n >= 4000) begin
         $display("BAD wait exp done got timeout");
         n_mismatch++;
         summarize();
      end
   endtask
   // Ready is sampled at the negedge; inputs only move after posedges
   task automatic wr(input logic [4:0] a, input logic [31:0] dd, input logic [1:0] er);
      int n;
      logic r;
      logic [1:0] rs;
      awaddr <= a;
      wdata <= dd;
      awvalid <= 1;
      wvalid <= 1;
      n = 0;
      do begin @(negedge clk); r = awready; @(posedge clk); n++; end while (r !== 1 && n < 4000);
      tmo(n);
      awvalid <= 0;
      wvalid <= 0;
      bready <= 1;
      n = 0;
      do begin @(negedge clk); r = bvalid; rs = bresp; @(posedge clk); n++; end
      while (r !== 1 && n < 4000);
      tmo(n);
      bready <= 0;
      chk("bresp", er, rs);
   endtask
   task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] q);
      int n;
      logic r;
      logic [1:0] rs;
      araddr <= a;
      arvalid <= 1;
      n = 0;
      do begin @(negedge clk); r = arready; @(posedge clk); n++; end while (r !== 1 && n < 4000);
      tmo(n);
      arvalid <= 0;
      rready <= 1;
      n = 0;
      do begin @(negedge clk); r = rvalid; q = rdata; rs = rresp; @(posedge clk); n++; end
      while (r !== 1 && n < 4000);
      tmo(n);
      rready <= 0;
      chk("rresp", er, rs);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      rd(a, RESP_OKAY, q);
      chk(nm, e, q);
   endtask
   // Software order: driver off, period, mode, duty, flag, timebase, wait, driver on
   task automatic cfg(input int ps);
      int n;
      logic [31:0] q;
      wr(OFS_PIN, 32'h1, RESP_OKAY);
      wr(OFS_PERIOD, p, RESP_OKAY);
      wr(OFS_MODE, {d[1:0], MODE_PWM, 2'h0}, RESP_OKAY);
      wr(OFS_DUTY_HI, d >> 2, RESP_OKAY);
      wr(OFS_FLAGS, 32'h1, RESP_OKAY);
      wr(OFS_TB_CTRL, 4 | ps, RESP_OKAY);
      n = 0;
      do begin rd(OFS_FLAGS, RESP_OKAY, q); n++; end while (q[0] !== 1 && n < 4000);
      tmo(n);
      wr(OFS_PIN, 32'h0, RESP_OKAY);
   endtask
   // One full cycle of the line: high time and rise-to-rise period
   task automatic meas(output int hi, output int pe);
      int n;
      n = 0;
      do begin @(negedge clk); n++; end while (line !== 0 && n < 4000);
      do begin @(negedge clk); n++; end while (line !== 1 && n < 4000);
      hi = 0;
      do begin @(negedge clk); hi++; n++; end while (line === 1 && n < 4000);
      pe = hi;
      do begin @(negedge clk); pe++; n++; end while (line === 0 && n < 4000);
      tmo(n);
      @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      chk("oe", 0, oe);
      rdc(OFS_PERIOD, RST_PERIOD, "period");
      rdc(OFS_PIN, RST_PIN, "pin");
      rdc(OFS_MODE, 0, "mode");
      rdc(OFS_STATUS, 0, "status");
      v = xs() | 1;
      wr(v[4:0], xs(), RESP_SLVERR);
      rd(v[4:0], RESP_SLVERR, v);
      chk("unaligned", 0, v);
      $display("test reset and decode done");
      // Same period throughout, so the count never sits above it
      p = 3 + xs() % 8;
      for (int ps = 3; ps >= 0; ps--) begin
         nn = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
         // Top value meets the match edge at prescale one; full duty runs later
         d = xs() % (4 * (p + 1) - 1);
         cfg(ps);
         chk("oe", 1, oe);
         meas(h, per);
         chk("period", 4 * nn * (p + 1), per);
         chk("high", 4 * nn * (d / 4) + d % 4 + 1, h);
      end
      $display("test prescale and duty done");
      wr(OFS_CAP_UPPER, 32'hA5, RESP_OKAY);
      rdc(OFS_CAP_UPPER, 0, "cap_upper");
      // Sleep freezes count and pin, then counting resumes
      slp <= 1;
      rd(OFS_STATUS, RESP_OKAY, s1);
      repeat (20) @(posedge clk);
      rd(OFS_STATUS, RESP_OKAY, v);
      chk("sleep", s1, v);
      chk("line", s1[8], line);
      slp <= 0;
      repeat (6) @(posedge clk);
      rd(OFS_STATUS, RESP_OKAY, v);
      chk("resume", 1, v[7:0] !== s1[7:0]);
      d = 4 * (p + 1);
      wr(OFS_DUTY_HI, d >> 2, RESP_OKAY);
      repeat (8 * (p + 1)) @(posedge clk);
      h = 0;
      repeat (4 * (p + 1)) begin @(negedge clk); h += (line === 1); end
      @(posedge clk);
      chk("full", 4 * (p + 1), h);
      $display("test sleep and full duty done");
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      chk("oe", 0, oe);
      rdc(OFS_PERIOD, RST_PERIOD, "period");
      rdc(OFS_TB_CTRL, 0, "ctrl");
      wr(OFS_CAP_UPPER, 32'h5A, RESP_OKAY);
      rdc(OFS_CAP_UPPER, 32'h5A, "cap_plain");
      wstrb <= 4'h0;
      wr(OFS_PERIOD, 32'h0, RESP_OKAY);
      wstrb <= 4'hF;
      rdc(OFS_PERIOD, RST_PERIOD, "lane0");
      wr(OFS_PIN, 32'h2, RESP_OKAY);
      chk("latch", 1, line);
      $display("test second reset done");
      summarize();
   end
endmodule // test_timer_based_pwm_output

// [tpwm_axil.sv]
`timescale 1ns/1ps
module tpwm_axil
   import tpwm_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] awaddr_i,
   input  wire logic              awvalid_i,
   output logic                   awready_o,
   input  wire logic [31:0]       wdata_i,
   input  wire logic [3:0]        wstrb_i,
   input  wire logic              wvalid_i,
   output logic                   wready_o,
   output logic [1:0]             bresp_o,
   output logic                   bvalid_o,
   input  wire logic              bready_i,
   input  wire logic [ADDR_W-1:0] araddr_i,
   input  wire logic              arvalid_i,
   output logic                   arready_o,
   output logic [31:0]            rdata_o,
   output logic [1:0]             rresp_o,
   output logic                   rvalid_o,
   input  wire logic              rready_i,
   tpwm_reg_if.bus                rif
);
   // -----------------------------------------------------------
   // Write: both channels taken together, response held until ready
   // -----------------------------------------------------------
   logic take_w;
   assign take_w      = awvalid_i && wvalid_i && !bvalid_o;
   assign awready_o   = take_w;
   assign wready_o    = take_w;
   assign rif.wr_en   = take_w && wstrb_i[0] && tpwm_mapped(awaddr_i); // Lane 0 only
   assign rif.wr_addr = awaddr_i;
   assign rif.wr_data = wdata_i[7:0];

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         bvalid_o <= 1'b0;
         bresp_o  <= RESP_OKAY;
      end else if (take_w) begin
         bvalid_o <= 1'b1;
         bresp_o  <= tpwm_mapped(awaddr_i) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_i) begin
         bvalid_o <= 1'b0;
      end
   end

   // -----------------------------------------------------------
   // Read: data captured at the address handshake
   // -----------------------------------------------------------
   assign arready_o   = arvalid_i && !rvalid_o;
   assign rif.rd_addr = araddr_i;

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rvalid_o <= 1'b0;
         rdata_o  <= 32'h0000_0000;
         rresp_o  <= RESP_OKAY;
      end else if (arready_o) begin
         rvalid_o <= 1'b1;
         rdata_o  <= rif.rd_data;
         rresp_o  <= tpwm_mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready_i) begin
         rvalid_o <= 1'b0;
      end
   end
endmodule // tpwm_axil

// [tpwm_load.sv]
`timescale 1ns/1ps
// Load on the modulated pin; the line has no pull, so undriven shows the inverse
module tpwm_load (
   input  wire logic clock_i,
   input  wire logic pin_i,
   input  wire logic oe_i,
   output logic      line_o
);
   logic last_reg = 1'b0;
   // Remember last driven level so a released line never reads as the old value
   always_ff @(posedge clock_i) begin
      if (oe_i) last_reg <= pin_i;
   end
   assign line_o = oe_i ? pin_i : ~last_reg;
endmodule // tpwm_load

// [tpwm_pkg.sv]
package tpwm_pkg;

   // -----------------------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------------------
   localparam int          ADDR_W         = 5;
   localparam logic [4:0]  OFS_PERIOD     = 5'h00;
   localparam logic [4:0]  OFS_TB_CTRL    = 5'h04;
   localparam logic [4:0]  OFS_DUTY_HI    = 5'h08;
   localparam logic [4:0]  OFS_CAP_UPPER  = 5'h0C;
   localparam logic [4:0]  OFS_MODE       = 5'h10;
   localparam logic [4:0]  OFS_FLAGS      = 5'h14;
   localparam logic [4:0]  OFS_PIN        = 5'h18;
   localparam logic [4:0]  OFS_STATUS     = 5'h1C;

   // -----------------------------------------------------------
   // Fields and reset values
   // -----------------------------------------------------------
   localparam int          TB_RUN_BIT     = 2;
   localparam int          MODE_LO_POS    = 4;
   localparam int          FLAG_MATCH_BIT = 0;
   localparam int          PIN_DIR_BIT    = 0;
   localparam int          PIN_LATCH_BIT  = 1;
   localparam int          STAT_PIN_BIT   = 8;
   localparam logic [1:0]  MODE_PWM       = 2'h3;
   localparam logic [7:0]  RST_PERIOD     = 8'hFF;
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [1:0]  RST_PIN        = 2'h1;
   localparam logic [1:0]  PHASE_LAST     = 2'h3;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Address decode shared by write and read paths
   function automatic logic tpwm_mapped(input logic [ADDR_W-1:0] a);
      return (a[1:0] == 2'h0);
   endfunction

endpackage

// [tpwm_reg_if.sv]
`timescale 1ns/1ps
// Register access between bus slave and register file
interface tpwm_reg_if;
   import tpwm_pkg::*;
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [7:0]        wr_data;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0]       rd_data;
   modport bus  (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport regs (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface // tpwm_reg_if

// [tpwm_timebase.sv]
`timescale 1ns/1ps
module tpwm_timebase
   import tpwm_pkg::*;
#(
   parameter int PRE_W = 4
)(
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic       sleep_i,
   input  wire logic [1:0] presc_sel_i,
   input  wire logic [7:0] period_i,
   output logic [7:0]      count_o,
   output logic [1:0]      frac_o,
   output logic            match_o
);
   logic [1:0]       phase_reg;
   logic [PRE_W-1:0] pre_reg;
   logic [PRE_W-1:0] pre_limit;
   logic             active;
   logic             tick;

   // -----------------------------------------------------------
   // Prescaler: four clock phases, then 1, 4 or 16 phase rounds
   // -----------------------------------------------------------
   always_comb begin
      unique case (presc_sel_i)
         2'h0:    pre_limit = PRE_W'(0);
         2'h1:    pre_limit = PRE_W'(3);
         default: pre_limit = PRE_W'(15);
      endcase
   end
   assign active = run_i && !sleep_i;
   assign tick   = active && (phase_reg == PHASE_LAST) && (pre_reg == pre_limit);

   // Phase runs off the system clock alone, never a separate source
   always_ff @(posedge clock_i) begin
      if (rst_i)       phase_reg <= 2'h0;
      else if (active) phase_reg <= phase_reg + 2'h1;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pre_reg <= '0;
      end else if (active && phase_reg == PHASE_LAST) begin
         pre_reg <= (pre_reg == pre_limit) ? '0 : pre_reg + PRE_W'(1);
      end
   end

   // Counter restarts on period match; holds value through sleep
   always_ff @(posedge clock_i) begin
      if (rst_i)     count_o <= 8'h00;
      else if (tick) count_o <= (count_o == period_i) ? 8'h00 : count_o + 8'h01;
   end

   assign frac_o  = phase_reg;
   assign match_o = tick && (count_o == period_i);

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   a_sleep_freeze: assert property (@(posedge clock_i) disable iff (rst_i)
      sleep_i |=> $stable(count_o) && $stable(phase_reg))
      else $error("timebase moved during sleep");
   a_match_wrap: assert property (@(posedge clock_i) disable iff (rst_i)
      match_o |=> count_o == 8'h00)
      else $error("count did not restart after match");
   a_stopped_hold: assert property (@(posedge clock_i) disable iff (rst_i)
      !run_i |=> $stable(count_o))
      else $error("count moved while disabled");
endmodule // tpwm_timebase

// [tpwm_top.sv]
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module tpwm_top
   import tpwm_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   input  wire logic              sleep_i,
   output logic                   modulated_output_pin_o,
   output logic                   modulated_output_pin_oe_o
);

   // -----------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------
   tpwm_reg_if rif ();

   logic [7:0] timebase_period_reg;
   logic [2:0] timebase_control_reg;
   logic [7:0] duty_high_byte_reg;
   logic [7:0] capture_upper_byte_reg;
   logic [5:0] ccp_mode_control_reg;
   logic       timebase_match_flag_reg;
   logic [1:0] pin_ctrl_reg;
   logic [9:0] duty_latch_reg;
   logic       pwm_level_reg;

   logic [7:0] timebase_counter;
   logic [1:0] tb_frac;
   logic       tb_match;
   logic       pwm_mode;
   logic       pin_direction_bit;
   logic       duty_hit;
   logic       flag_clear;
   logic [9:0] duty_next;

   // -----------------------------------------------------------
   // Bus slave
   // -----------------------------------------------------------
   tpwm_axil u_axil (
      .clock_i   (clock_i),
      .rst_i     (rst_i),
      .awaddr_i  (s_axi_awaddr_i),
      .awvalid_i (s_axi_awvalid_i),
      .awready_o (s_axi_awready_o),
      .wdata_i   (s_axi_wdata_i),
      .wstrb_i   (s_axi_wstrb_i),
      .wvalid_i  (s_axi_wvalid_i),
      .wready_o  (s_axi_wready_o),
      .bresp_o   (s_axi_bresp_o),
      .bvalid_o  (s_axi_bvalid_o),
      .bready_i  (s_axi_bready_i),
      .araddr_i  (s_axi_araddr_i),
      .arvalid_i (s_axi_arvalid_i),
      .arready_o (s_axi_arready_o),
      .rdata_o   (s_axi_rdata_o),
      .rresp_o   (s_axi_rresp_o),
      .rvalid_o  (s_axi_rvalid_o),
      .rready_i  (s_axi_rready_i),
      .rif       (rif.bus)
   );

   // -----------------------------------------------------------
   // Timebase
   // -----------------------------------------------------------
   tpwm_timebase #(.PRE_W(4)) u_timebase (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .run_i       (timebase_control_reg[TB_RUN_BIT]),
      .sleep_i     (sleep_i),
      .presc_sel_i (timebase_control_reg[1:0]),
      .period_i    (timebase_period_reg),
      .count_o     (timebase_counter),
      .frac_o      (tb_frac),
      .match_o     (tb_match)
   );

   // -----------------------------------------------------------
   // Decodes
   // -----------------------------------------------------------
   assign pwm_mode          = (ccp_mode_control_reg[3:2] == MODE_PWM);
   assign pin_direction_bit = pin_ctrl_reg[PIN_DIR_BIT];
   assign flag_clear        = rif.wr_en && rif.wr_addr == OFS_FLAGS
                              && rif.wr_data[FLAG_MATCH_BIT];
   // Ten-bit duty assembled from byte and mode bits 5:4 as its low bits
   assign duty_next = {duty_high_byte_reg,
                       ccp_mode_control_reg[MODE_LO_POS+1:MODE_LO_POS]};
   // Extended count compares against latched duty
   assign duty_hit  = ({timebase_counter, tb_frac} == duty_latch_reg);

   // -----------------------------------------------------------
   // Software-written configuration
   // -----------------------------------------------------------
   // Period is always writable; software loads it before mode select
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         timebase_period_reg <= RST_PERIOD;
      end else if (rif.wr_en && rif.wr_addr == OFS_PERIOD) begin
         timebase_period_reg <= rif.wr_data;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         timebase_control_reg <= 3'h0;
      end else if (rif.wr_en && rif.wr_addr == OFS_TB_CTRL) begin
         timebase_control_reg <= rif.wr_data[2:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         duty_high_byte_reg <= RST_BYTE;
      end else if (rif.wr_en && rif.wr_addr == OFS_DUTY_HI) begin
         duty_high_byte_reg <= rif.wr_data;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ccp_mode_control_reg <= 6'h00;
      end else if (rif.wr_en && rif.wr_addr == OFS_MODE) begin
         ccp_mode_control_reg <= rif.wr_data[5:0];
      end
   end

   // Upper byte frozen while modulating; only plain modes may load it
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         capture_upper_byte_reg <= RST_BYTE;
      end else if (rif.wr_en && rif.wr_addr == OFS_CAP_UPPER && !pwm_mode) begin
         capture_upper_byte_reg <= rif.wr_data;
      end
   end

   // Direction resets to input so nothing drives until software allows it
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pin_ctrl_reg <= RST_PIN;
      end else if (rif.wr_en && rif.wr_addr == OFS_PIN) begin
         pin_ctrl_reg <= rif.wr_data[1:0];
      end
   end

   // -----------------------------------------------------------
   // Match flag: a match in the clearing cycle keeps the flag set
   // -----------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         timebase_match_flag_reg <= 1'b0;
      end else if (tb_match) begin
         timebase_match_flag_reg <= 1'b1;
      end else if (flag_clear) begin
         timebase_match_flag_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------
   // Modulator
   // -----------------------------------------------------------
   // Duty is double buffered so a mid-period write cannot glitch
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         duty_latch_reg <= 10'h000;
      end else if (tb_match) begin
         duty_latch_reg <= duty_next;
      end
   end

   // Level moves on timebase events and is forced low outside modulation mode; sleep leaves it untouched
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pwm_level_reg <= 1'b0;
      end else if (!pwm_mode) begin
         pwm_level_reg <= 1'b0;
      end else if (sleep_i) begin
         pwm_level_reg <= pwm_level_reg;
      end else if (tb_match) begin
         pwm_level_reg <= 1'b1;
      end else if (duty_hit) begin
         pwm_level_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------
   // Pin: shared with the port latch, driver gated by direction
   // -----------------------------------------------------------
   assign modulated_output_pin_o    = pwm_mode ? pwm_level_reg
                                               : pin_ctrl_reg[PIN_LATCH_BIT];
   assign modulated_output_pin_oe_o = !pin_direction_bit;

   // -----------------------------------------------------------
   // Read mux
   // -----------------------------------------------------------
   always_comb begin
      rif.rd_data = 32'h0000_0000;
      unique case (rif.rd_addr)
         OFS_PERIOD:    rif.rd_data[7:0] = timebase_period_reg;
         OFS_TB_CTRL:   rif.rd_data[2:0] = timebase_control_reg;
         OFS_DUTY_HI:   rif.rd_data[7:0] = duty_high_byte_reg;
         OFS_CAP_UPPER: rif.rd_data[7:0] = capture_upper_byte_reg;
         OFS_MODE:      rif.rd_data[5:0] = ccp_mode_control_reg;
         OFS_FLAGS:     rif.rd_data[FLAG_MATCH_BIT] = timebase_match_flag_reg;
         OFS_PIN:       rif.rd_data[1:0] = pin_ctrl_reg;
         OFS_STATUS: begin
            rif.rd_data[7:0]          = timebase_counter;
            rif.rd_data[STAT_PIN_BIT] = modulated_output_pin_o;
         end
         default:       rif.rd_data = 32'h0000_0000;
      endcase
   end

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   sequence s_cap_write;
      rif.wr_en && rif.wr_addr == OFS_CAP_UPPER && pwm_mode;
   endsequence

   sequence s_period_end;
      tb_match && pwm_mode && !sleep_i;
   endsequence

   sequence s_flag_clear;
      flag_clear && !tb_match;
   endsequence

   a_cap_readonly: assert property (@(posedge clock_i) disable iff (rst_i)
      s_cap_write |=> $stable(capture_upper_byte_reg))
      else $error("upper byte changed in modulation mode");

   a_period_high: assert property (@(posedge clock_i) disable iff (rst_i)
      s_period_end |=> pwm_level_reg && timebase_match_flag_reg
                       && duty_latch_reg == $past(duty_next))
      else $error("period start did not set level, flag and duty");

   a_duty_low: assert property (@(posedge clock_i) disable iff (rst_i)
      pwm_mode && !sleep_i && !tb_match && duty_hit |=> !pwm_level_reg)
      else $error("duty compare did not drop level");

   a_sleep_level: assert property (@(posedge clock_i) disable iff (rst_i)
      sleep_i && $past(sleep_i) && pwm_mode |-> $stable(modulated_output_pin_o))
      else $error("pin level moved during sleep");

   a_flag_set_wins: assert property (@(posedge clock_i) disable iff (rst_i)
      tb_match && flag_clear |=> timebase_match_flag_reg)
      else $error("match lost against clear");

   a_reset_input: assert property (@(posedge clock_i)
      rst_i |=> !modulated_output_pin_oe_o && !pwm_level_reg
                && timebase_period_reg == RST_PERIOD)
      else $error("reset did not return pin to input");

   // A rise in modulation mode is only legal right after a period match
   a_pin_driver: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(modulated_output_pin_o) && pwm_mode && $past(pwm_mode) |-> $past(tb_match))
      else $error("modulated pin rose outside a period start");

   // Register loads land at the edge after the bus takes the write
   a_period_load: assert property (@(posedge clock_i) disable iff (rst_i)
      rif.wr_en && rif.wr_addr == OFS_PERIOD |=> timebase_period_reg == $past(rif.wr_data))
      else $error("period write did not land");

   a_ctrl_load: assert property (@(posedge clock_i) disable iff (rst_i)
      rif.wr_en && rif.wr_addr == OFS_TB_CTRL |=> timebase_control_reg == $past(rif.wr_data[2:0]))
      else $error("control write did not land");

   a_duty_load: assert property (@(posedge clock_i) disable iff (rst_i)
      rif.wr_en && rif.wr_addr == OFS_DUTY_HI |=> duty_high_byte_reg == $past(rif.wr_data))
      else $error("duty write did not land");

   a_mode_load: assert property (@(posedge clock_i) disable iff (rst_i)
      rif.wr_en && rif.wr_addr == OFS_MODE |=> ccp_mode_control_reg == $past(rif.wr_data[5:0]))
      else $error("mode write did not land");

   // Between period starts the flag, level and latch move only as told
   a_flag_clear: assert property (@(posedge clock_i) disable iff (rst_i)
      s_flag_clear |=> !timebase_match_flag_reg)
      else $error("flag survived a clear");

   a_mode_exit: assert property (@(posedge clock_i) disable iff (rst_i)
      !pwm_mode |=> !pwm_level_reg)
      else $error("level stayed up outside modulation");

   a_latch_hold: assert property (@(posedge clock_i) disable iff (rst_i)
      !tb_match |=> $stable(duty_latch_reg))
      else $error("duty latch moved inside a period");

endmodule // tpwm_top
